// [asr_sequencer.sv]
// converter sequencer: apb registers, sample/approximation control, result formatting
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
module asr_sequencer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comp_in,
	output logic [asr_pkg::NUM_AIN-1:0] ain_select,
	output logic high_ref_select,
	output logic low_ref_select,
	output logic sample_enable,
	output logic [asr_pkg::RESULT_BITS-1:0] sar_trial,
	output logic done_irq
);
	import asr_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	asr_state_t state_q;
	asr_state_t state_d;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic justify_select_q;
	logic resolution_select_q;
	logic signed_output_select_q;
	logic [3:0] clock_divider_field_q;
	logic done_irq_enable_q;
	logic continuous_convert_q;
	logic [4:0] channel_select_q;
	logic conversion_done_flag_q;
	logic done_irq_q;
	logic [7:0] result_high_byte_q;
	logic [7:0] result_low_byte_q;
	logic [9:0] sar_code_q;
	logic [9:0] sar_next;
	logic [3:0] bit_idx_q;
	logic [3:0] sample_cnt_q;
	logic comp_meta_q;
	logic comp_sync_q;
	logic comp_eff;
	logic [NUM_AIN-1:0] ain_select_q;
	logic high_ref_q;
	logic low_ref_q;
	logic sample_enable_q;
	logic apb_done;
	logic ctrl_wr;
	logic sc_wr;
	logic res_rd;
	logic mapped;
	logic conv_tick;
	logic div_restart;
	logic [7:0] fmt_hi;
	logic [7:0] fmt_lo;
	logic [7:0] read_byte;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// one wait state: pready is raised in the second access cycle
	assign apb_done = psel && penable && pready_q;
	assign ctrl_wr = apb_done && pwrite && pstrb[0] && (paddr == OFF_CTRL);
	assign sc_wr = apb_done && pwrite && pstrb[0] && (paddr == OFF_SC);
	assign res_rd = apb_done && !pwrite && ((paddr == OFF_RES_HI) || (paddr == OFF_RES_LO));
	assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_SC) ||
		(paddr == OFF_RES_HI) || (paddr == OFF_RES_LO);

	// read mux, reserved and unused bits read zero
	always_comb begin
		read_byte = 8'h00;
		case (paddr)
			OFF_CTRL: read_byte = {1'b0, justify_select_q, resolution_select_q,
				signed_output_select_q, clock_divider_field_q};
			OFF_SC: read_byte = {conversion_done_flag_q, done_irq_enable_q,
				continuous_convert_q, channel_select_q};
			OFF_RES_HI: read_byte = result_high_byte_q;
			OFF_RES_LO: read_byte = result_low_byte_q;
			default: read_byte = 8'h00;
		endcase
	end

	// bus answer registers; unmapped addresses complete with pslverr
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (psel && penable && !pready_q) begin
				pready_q <= 1'b1;
				pslverr_q <= !mapped;
				prdata_q <= {24'h00_0000, read_byte};
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// format and prescaler settings; only the low byte lane is used
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			justify_select_q <= RST_JUSTIFY;
			resolution_select_q <= RST_RESOLUTION_SELECT;
			signed_output_select_q <= RST_SIGNED;
			clock_divider_field_q <= RST_DIV;
		end else if (ce && ctrl_wr) begin
			justify_select_q <= pwdata[CTRL_JUSTIFY_BIT];
			resolution_select_q <= pwdata[CTRL_RESOLUTION_SELECT_BIT];
			signed_output_select_q <= pwdata[CTRL_SIGNED_BIT];
			clock_divider_field_q <= pwdata[CTRL_DIV_MSB:0];
		end
	end

	// status/control writable fields; bit 7 is the read-only done flag
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			done_irq_enable_q <= RST_IRQ_EN;
			continuous_convert_q <= RST_CONT;
			channel_select_q <= RST_CHAN;
		end else if (ce && sc_wr) begin
			done_irq_enable_q <= pwdata[SC_IRQ_EN_BIT];
			continuous_convert_q <= pwdata[SC_CONT_BIT];
			channel_select_q <= pwdata[SC_CHAN_MSB:0];
		end
	end

	// done flag: a finishing conversion wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			conversion_done_flag_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_TRANSFER) begin
				conversion_done_flag_q <= 1'b1;
			end else if (sc_wr || res_rd) begin
				conversion_done_flag_q <= 1'b0;
			end
		end
	end

	// interrupt pending one clock after flag and enable are both set; a status/control write drops it at once
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			done_irq_q <= 1'b0;
		end else if (ce) begin
			done_irq_q <= conversion_done_flag_q && done_irq_enable_q && !sc_wr;
		end
	end

	// ----------------------------------------------------------------
	// conversion clock and comparator input
	// ----------------------------------------------------------------
	// restart on every start, abort and turnaround keeps sample windows whole
	assign div_restart = sc_wr || ctrl_wr || (state_q == ST_TRANSFER);

	asr_clk_div u_clk_div (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.ce(ce),
		.restart(div_restart),
		.div_field(clock_divider_field_q),
		.tick(conv_tick)
	);

	// comparator comes from the analog side, so it is synchronised first
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			comp_meta_q <= 1'b0;
			comp_sync_q <= 1'b0;
		end else if (ce) begin
			comp_meta_q <= comp_in;
			comp_sync_q <= comp_meta_q;
		end
	end

	// references are resolved internally without the sampled input
	assign comp_eff = high_ref_q ? 1'b1 : (low_ref_q ? 1'b0 : comp_sync_q);

	// ----------------------------------------------------------------
	// channel selection
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_AIN; gi++) begin : g_ain
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					ain_select_q[gi] <= 1'b0;
				end else if (ce) begin
					ain_select_q[gi] <= (channel_select_q == 5'(gi));
				end
			end
		end
	endgenerate

	// reserved codes fall back to the low reference
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			high_ref_q <= 1'b0;
			low_ref_q <= 1'b0;
		end else if (ce) begin
			high_ref_q <= (channel_select_q == CHAN_HIGH_REF);
			low_ref_q <= (channel_select_q > CHAN_LAST_AIN) &&
				(channel_select_q != CHAN_HIGH_REF);
		end
	end

	// ----------------------------------------------------------------
	// sequencer state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (ctrl_wr) begin
			state_d = ST_IDLE;
		end else if (sc_wr) begin
			state_d = ST_SAMPLE;
		end else begin
			case (state_q)
				ST_IDLE: state_d = ST_IDLE;
				ST_SAMPLE: begin
					if (conv_tick && sample_cnt_q == SAMPLE_LAST) begin
						state_d = ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (conv_tick && bit_idx_q == 4'h0) begin
						state_d = ST_TRANSFER;
					end
				end
				ST_TRANSFER: state_d = continuous_convert_q ? ST_SAMPLE : ST_IDLE;
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// sample window counter, cleared whenever a window opens
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_cnt_q <= 4'h0;
		end else if (ce) begin
			if (state_d == ST_SAMPLE && (state_q != ST_SAMPLE || sc_wr)) begin
				sample_cnt_q <= 4'h0;
			end else if (state_q == ST_SAMPLE && conv_tick) begin
				sample_cnt_q <= sample_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_enable_q <= 1'b0;
		end else if (ce) begin
			sample_enable_q <= (state_d == ST_SAMPLE);
		end
	end

	// successive approximation: keep or drop the trial bit, then try the next
	always_comb begin
		sar_next = sar_code_q;
		sar_next[bit_idx_q] = comp_eff;
		if (bit_idx_q != 4'h0) begin
			sar_next[bit_idx_q - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sar_code_q <= 10'h000;
			bit_idx_q <= 4'h0;
		end else if (ce) begin
			if (state_d == ST_CONVERT && state_q != ST_CONVERT) begin
				sar_code_q <= SAR_FIRST_TRIAL;
				bit_idx_q <= SAR_FIRST_IDX;
			end else if (state_q == ST_CONVERT && conv_tick && state_d == ST_CONVERT) begin
				sar_code_q <= sar_next;
				bit_idx_q <= bit_idx_q - 4'h1;
			end else if (state_q == ST_CONVERT && conv_tick) begin
				sar_code_q <= sar_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// result formatting
	// ----------------------------------------------------------------
	always_comb begin
		fmt_hi = 8'h00;
		fmt_lo = 8'h00;
		if (resolution_select_q) begin
			// justify does not move the result; sign only honoured when left justified
			fmt_hi = {sar_code_q[9] ^ (signed_output_select_q && !justify_select_q),
				sar_code_q[8:2]};
			fmt_lo = 8'h00;
		end else if (!justify_select_q) begin
			fmt_hi = {sar_code_q[9] ^ signed_output_select_q, sar_code_q[8:2]};
			fmt_lo = {sar_code_q[1:0], 6'h00};
		end else begin
			fmt_hi = {6'h00, sar_code_q[9:8]};
			fmt_lo = sar_code_q[7:0];
		end
	end

	// results move only at the end of a conversion, so reads see whole codes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_high_byte_q <= 8'h00;
			result_low_byte_q <= 8'h00;
		end else if (ce && state_q == ST_TRANSFER) begin
			result_high_byte_q <= fmt_hi;
			result_low_byte_q <= fmt_lo;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ain_select = ain_select_q;
	assign high_ref_select = high_ref_q;
	assign low_ref_select = low_ref_q;
	assign sample_enable = sample_enable_q;
	assign sar_trial = sar_code_q;
	assign done_irq = done_irq_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_transfer;
		ce && state_q == ST_TRANSFER;
	endsequence

	a_fmt_eight_unsigned: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (resolution_select_q && !(signed_output_select_q && !justify_select_q)))
		|=> (result_high_byte_q == $past(sar_code_q[9:2]) && result_low_byte_q == 8'h00))
		else $error("8-bit unsigned result misplaced");

	a_fmt_eight_signed: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (resolution_select_q && signed_output_select_q && !justify_select_q))
		|=> (result_high_byte_q == {~$past(sar_code_q[9]), $past(sar_code_q[8:2])}))
		else $error("8-bit signed result wrong");

	a_fmt_ten_left: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (!resolution_select_q && !justify_select_q && !signed_output_select_q))
		|=> (result_high_byte_q == $past(sar_code_q[9:2]) &&
		result_low_byte_q == {$past(sar_code_q[1:0]), 6'h00}))
		else $error("10-bit left unsigned result wrong");

	a_fmt_ten_signed: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (!resolution_select_q && !justify_select_q && signed_output_select_q))
		|=> (result_high_byte_q[7] == !$past(sar_code_q[9]) &&
		result_low_byte_q[5:0] == 6'h00))
		else $error("10-bit signed result MSB not inverted");

	a_fmt_ten_right: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (!resolution_select_q && justify_select_q))
		|=> ({result_high_byte_q, result_low_byte_q} == {6'h00, $past(sar_code_q)}))
		else $error("right justified result wrong or signed");

	a_start_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && sc_wr && state_q != ST_TRANSFER)
		|=> (!conversion_done_flag_q && state_q == ST_SAMPLE && sample_cnt_q == 4'h0)
		##1 (ce -> !done_irq_q))
		else $error("status/control write did not restart and clear");

	a_done_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_transfer |=> conversion_done_flag_q)
		else $error("done flag not set at conversion end");

	a_read_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && res_rd && state_q != ST_TRANSFER) |=> !conversion_done_flag_q)
		else $error("result read did not clear done flag");

	a_irq_cause: assert property (@(posedge sys_clk) disable iff (!reset_n)
		done_irq_q |-> ($past(conversion_done_flag_q) && $past(done_irq_enable_q)))
		else $error("interrupt without flag and enable");

	a_repeat_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_transfer and (!sc_wr && !ctrl_wr)) |=>
		(state_q == (continuous_convert_q ? ST_SAMPLE : ST_IDLE)))
		else $error("wrong state after conversion end");

	a_ctrl_abort: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && ctrl_wr) |=> (state_q == ST_IDLE) ##1 (ce -> !sample_enable_q))
		else $error("control write did not abort conversion");

	a_sample_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && state_q == ST_SAMPLE && state_d == ST_CONVERT) |-> (sample_cnt_q == SAMPLE_LAST))
		else $error("sample window not 14 conversion clocks");

	a_chan_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && $stable(channel_select_q) && channel_select_q <= CHAN_LAST_AIN)
		|=> (ain_select_q == (8'h01 << $past(channel_select_q)) && !low_ref_q && !high_ref_q))
		else $error("analog input select does not match channel code");
endmodule : asr_sequencer

// [asr_pkg.sv]
// constants, types and field layout of the converter sequencer
package asr_pkg;
	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SC = 8'h04;
	localparam logic [7:0] OFF_RES_HI = 8'h08;
	localparam logic [7:0] OFF_RES_LO = 8'h0C;
	// ----------------------------------------------------------------
	// status/control field positions and reset values
	// ----------------------------------------------------------------
	localparam int SC_DONE_BIT = 7;
	localparam int SC_IRQ_EN_BIT = 6;
	localparam int SC_CONT_BIT = 5;
	localparam int SC_CHAN_MSB = 4;
	localparam logic RST_IRQ_EN = 1'b0;
	localparam logic RST_CONT = 1'b0;
	localparam logic [4:0] RST_CHAN = 5'h00;
	// ----------------------------------------------------------------
	// control register field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_JUSTIFY_BIT = 6;
	localparam int CTRL_RESOLUTION_SELECT_BIT = 5;
	localparam int CTRL_SIGNED_BIT = 4;
	localparam int CTRL_DIV_MSB = 3;
	localparam logic RST_JUSTIFY = 1'b0;
	localparam logic RST_RESOLUTION_SELECT = 1'b0;
	localparam logic RST_SIGNED = 1'b0;
	localparam logic [3:0] RST_DIV = 4'h0;
	// ----------------------------------------------------------------
	// channel coding and conversion timing
	// ----------------------------------------------------------------
	localparam int NUM_AIN = 8;
	localparam logic [4:0] CHAN_LAST_AIN = 5'h07;
	localparam logic [4:0] CHAN_HIGH_REF = 5'h1E;
	localparam int RESULT_BITS = 10;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [3:0] SAR_FIRST_IDX = 4'h9;
	localparam logic [3:0] SAMPLE_LAST = 4'hD;
	localparam int SYS_CLK_PERIOD_NS = 10;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b11,
		ST_TRANSFER = 2'b10
	} asr_state_t;
endpackage : asr_pkg

// [asr_clk_div.sv]
// conversion clock prescaler producing one tick per conversion clock period
`timescale 1ns/1ns
module asr_clk_div (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic restart,
	input wire logic [asr_pkg::CTRL_DIV_MSB:0] div_field,
	output logic tick
);
	import asr_pkg::*;

	logic [4:0] count_q;
	logic [4:0] limit;
	logic [5:0] gap_q;

	// period is 2*(field+1) bus clocks, so the last count is 2*field+1
	assign limit = {div_field, 1'b1};
	assign tick = (count_q == limit) && !restart;

	// ----------------------------------------------------------------
	// divider counter
	// ----------------------------------------------------------------
	// restart realigns the period so a new conversion always sees full periods
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 5'h00;
		end else if (ce) begin
			if (restart || count_q >= limit) begin
				count_q <= 5'h00;
			end else begin
				count_q <= count_q + 5'h01;
			end
		end
	end

	// checking aid: bus clocks since the last tick or restart
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= 6'h00;
		end else if (ce) begin
			if (restart || tick) begin
				gap_q <= 6'h00;
			end else if (gap_q != 6'h3F) begin
				gap_q <= gap_q + 6'h01;
			end
		end
	end

	a_tick_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(ce && tick && $stable(div_field)) |-> (gap_q == {1'b0, limit}))
		else $error("conversion tick period differs from prescaler setting");
endmodule : asr_clk_div

// [adc_sequencer_result_format_test.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adc_sequencer_result_format_test;
	import asr_pkg::*;
	logic sys_clk, reset_n, ce, psel, penable, pwrite, comp_in, pready, pslverr, er;
	logic high_ref_select, low_ref_select, sample_enable, done_irq;
	logic [7:0] paddr, ain_select, rd;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [9:0] sar_trial, level;
	int miscompares, n_compared;

	asr_sequencer i_asr_sequencer (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
		.ain_select(ain_select), .high_ref_select(high_ref_select),
		.low_ref_select(low_ref_select), .sample_enable(sample_enable),
		.sar_trial(sar_trial), .done_irq(done_irq));

	// ----------------------------------------------------------------
	// clock, comparator stand-in and watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ideal comparator: the extra flop only adds latency the synchroniser already tolerates
	always @(posedge sys_clk) comp_in <= (level >= sar_trial);
	// the whole run needs well under half of this span
	initial begin
		#900000;
		miscompares++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a stalled transfer
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic wait_done();
		int n;
		n = 0;
		rd = 8'h00;
		while (rd[7] !== 1'b1 && n < 300) begin
			apb(1'b0, OFF_SC, 8'h00);
			n++;
		end
		chk("done flag", rd[7], 1'b1);
	endtask : wait_done
	function automatic logic [15:0] fmt(input logic [9:0] v, input logic r8, dj, sg);
		logic [9:0] w;
		w = (sg && !dj) ? (v ^ 10'h200) : v;
		if (r8) return {w[9:2], 8'h00};
		if (dj) return {6'h00, v};
		return {w[9:2], w[1:0], 6'h00};
	endfunction : fmt

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] offs [4];
		offs = '{OFF_CTRL, OFF_SC, OFF_RES_HI, OFF_RES_LO};
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 8'h00);
			chk("reset value", rd, 8'h00);
		end
		chk("irq after reset", done_irq, 1'b0);
		apb(1'b0, 8'h10, 8'h00);
		chk("unmapped error", er, 1'b1);
		apb(1'b1, OFF_RES_HI, 8'h55);
		apb(1'b0, OFF_RES_HI, 8'h00);
		chk("result read only", rd, 8'h00);
	endtask : t_reset
	// every format against full scale, low reference and a mid code on input three
	task automatic t_format();
		logic [4:0] chs [3];
		logic [9:0] vals [3];
		logic [15:0] e;
		chs = '{CHAN_HIGH_REF, 5'h1F, 5'h03};
		vals = '{10'h3FF, 10'h000, 10'h2A5};
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, OFF_CTRL, {1'b0, m[1], m[2], m[0], 4'h1});
			for (int k = 0; k < 3; k++) begin
				level = (k == 2) ? vals[k] : ~vals[k];
				e = fmt(vals[k], m[2], m[1], m[0]);
				apb(1'b1, OFF_SC, {3'b000, chs[k]});
				wait_done();
				apb(1'b0, OFF_RES_HI, 8'h00);
				chk("result high", rd, e[15:8]);
				apb(1'b0, OFF_SC, 8'h00);
				chk("flag after high read", rd[7], 1'b0);
				apb(1'b0, OFF_RES_LO, 8'h00);
				chk("result low", rd, e[7:0]);
			end
		end
	endtask : t_format
	task automatic t_chan();
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, OFF_SC, c[7:0] & 8'h1F);
			repeat (2) @(posedge sys_clk);
			chk("input select", ain_select, (c < 8) ? (8'h01 << c) : 8'h00);
			chk("ref select", {high_ref_select, low_ref_select},
				{c == 30, c >= 8 && c != 30});
		end
	endtask : t_chan
	// sample window length at both ends of the divider, then abort by control write
	task automatic t_prescale();
		int n;
		int cnt;
		int e;
		for (int d = 0; d < 16; d += 15) begin
			apb(1'b1, OFF_CTRL, d[7:0]);
			apb(1'b1, OFF_SC, 8'h1E);
			n = 0;
			while (sample_enable !== 1'b1 && n < 100) begin
				@(posedge sys_clk);
				n++;
			end
			cnt = 0;
			while (sample_enable === 1'b1 && cnt < 1000) begin
				@(posedge sys_clk);
				cnt++;
			end
			e = 14 * 2 * (d + 1);
			chk("sample window", cnt >= e - 2 && cnt <= e + 2, 1'b1);
			apb(1'b1, OFF_CTRL, 8'h01);
			repeat (400) @(posedge sys_clk);
			apb(1'b0, OFF_SC, 8'h00);
			chk("aborted flag", rd[7], 1'b0);
			chk("aborted sampling", sample_enable, 1'b0);
		end
	endtask : t_prescale
	task automatic t_irq();
		apb(1'b1, OFF_SC, 8'h5E);
		wait_done();
		repeat (2) @(posedge sys_clk);
		chk("irq raised", done_irq, 1'b1);
		apb(1'b1, OFF_SC, 8'h5E);
		chk("irq dropped by write", done_irq, 1'b0);
		apb(1'b0, OFF_SC, 8'h00);
		chk("flag cleared by write", rd[7], 1'b0);
		wait_done();
		apb(1'b0, OFF_RES_LO, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk("irq follows flag", done_irq, 1'b0);
		apb(1'b1, OFF_SC, 8'h5E);
		wait_done();
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("irq in reset", done_irq, 1'b0);
		reset_n <= 1'b1;
		@(posedge sys_clk);
	endtask : t_irq
	task automatic t_mode();
		apb(1'b1, OFF_CTRL, 8'h01);
		apb(1'b1, OFF_SC, 8'h3E);
		wait_done();
		apb(1'b0, OFF_RES_LO, 8'h00);
		wait_done();
		apb(1'b1, OFF_SC, 8'h1E);
		wait_done();
		apb(1'b0, OFF_RES_LO, 8'h00);
		pstrb <= 4'h0;
		apb(1'b1, OFF_SC, 8'h1E);
		pstrb <= 4'hF;
		repeat (300) @(posedge sys_clk);
		apb(1'b0, OFF_SC, 8'h00);
		chk("single stops", rd[7], 1'b0);
		chk("idle after single", sample_enable, 1'b0);
	endtask : t_mode

	// quarter-rate clock enable: divider 15 then keeps the conversion clock near 780 kHz
	task automatic t_freeze();
		logic [9:0] snap;
		logic [15:0] e;
		level = 10'h155;
		e = fmt(10'h155, 1'b0, 1'b0, 1'b0);
		apb(1'b1, OFF_CTRL, 8'h0F);
		apb(1'b1, OFF_SC, 8'h03);
		// enable dropped only between bus transfers, never inside one
		for (int i = 0; i < 800; i++) begin
			ce <= 1'b1;
			@(posedge sys_clk);
			ce <= 1'b0;
			repeat (3) @(posedge sys_clk);
			if (i == 500) begin
				snap = sar_trial;
				repeat (40) @(posedge sys_clk);
				chk("frozen trial", sar_trial, snap);
			end
		end
		ce <= 1'b1;
		@(posedge sys_clk);
		wait_done();
		apb(1'b0, OFF_RES_HI, 8'h00);
		chk("slow result high", rd, e[15:8]);
		apb(1'b0, OFF_RES_LO, 8'h00);
		chk("slow result low", rd, e[7:0]);
	endtask : t_freeze

	// reset, then run every scenario in turn
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, level, comp_in} = '0;
		ce = 1'b1;
		pstrb = 4'hF;
		miscompares = 0;
		n_compared = 0;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_format();
		t_chan();
		t_prescale();
		t_irq();
		t_mode();
		t_freeze();
		end_sim();
	end
endmodule : adc_sequencer_result_format_test
